//--- rtl/wdr_watchdog.v
// watchdog timer with keyed refresh, unlock, window mode and system reset output
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "wdr_defines.vh"

module wdr_watchdog #(
  parameter [31:0] TICK_DIV = `WDR_TICK_DIV
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg         system_reset,
  output wire        reset_cause_wdog
);

  reg  [7:0]  monitor_control_one;
  reg  [9:0]  monitor_control_two;
  reg  [7:0]  timeout_value_high;
  reg  [7:0]  timeout_value_low;
  reg  [7:0]  window_value_high;
  reg  [7:0]  window_value_low;
  reg  [15:0] monitor_count_reg;
  reg  [31:0] tick_cnt;
  reg         tick;
  reg         unlocked;
  reg         unlock_half;
  reg         refresh_half;
  reg         cause_half;
  reg         cfg_done;
  reg         ack;
  reg  [7:0]  rst_cnt;
  reg         cause_flag;
  reg  [31:0] next_readdata;

  wire        sel_word;
  wire [2:0]  idx;
  wire        wr;
  wire [15:0] wdata16;
  wire [7:0]  wdata8;
  wire        be_lo;
  wire [15:0] timeout;
  wire [15:0] window;
  wire        enabled;
  wire [1:0]  style;
  wire        cfg_open;
  wire        cnt_step;
  wire        win_ok;
  wire        wr_count;
  wire        wr_cause;
  wire        cfg_wr;
  wire        early_refresh;

  assign sel_word = (avs_address[1:0] == 2'b00);
  assign idx      = avs_address[4:2];
  assign wr       = avs_write & ack & sel_word;
  assign wdata16  = avs_writedata[15:0];
  assign wdata8   = avs_writedata[7:0];
  assign be_lo    = avs_byteenable[0];
  assign timeout  = {timeout_value_high, timeout_value_low};
  assign window   = {window_value_high, window_value_low};
  assign enabled  = monitor_control_one[`WDR_CTL1_ENABLE];
  assign style    = monitor_control_two[`WDR_STYLE_HI:`WDR_STYLE_LO];
  assign cfg_open = unlocked & (~cfg_done | monitor_control_one[`WDR_CTL1_ALLOW]);
  assign cnt_step = monitor_control_two[`WDR_CTL2_CLK_SEL] ? tick : 1'b1;
  assign win_ok   = (window == 16'h0000) | (monitor_count_reg >= window);

  // byte lane 0 carries every 8-bit register and the low half of each key
  assign wr_count = wr & be_lo & (idx == `WDR_IDX_COUNT);
  assign wr_cause = wr & be_lo & (idx == `WDR_IDX_CAUSE);
  assign cfg_wr   = wr & cfg_open;

  // one wait state on every access so that read data come from flip-flops
  assign avs_waitrequest  = (avs_read | avs_write) & ~ack;
  assign reset_cause_wdog = cause_flag;

  wire key_refresh = wr & be_lo & (idx == `WDR_IDX_COUNT) & (style == `WDR_STYLE_COUNT)
                     & refresh_half & (wdata16 == `WDR_KEY_REFRESH_B);
  wire pair_refresh = wr & be_lo & (idx == `WDR_IDX_CAUSE) & (style == `WDR_STYLE_PAIR)
                      & cause_half & (wdata8 == `WDR_KEY_CAUSE_B);
  wire single_refresh = wr & be_lo & (idx == `WDR_IDX_CAUSE)
                        & (style == `WDR_STYLE_SINGLE);
  wire refresh = (key_refresh | pair_refresh | single_refresh) & win_ok;
  wire expire  = enabled & (monitor_count_reg >= timeout) & ~refresh;

  // a keyed refresh that comes before the window opens is treated as runaway code
  assign early_refresh = enabled & (key_refresh | pair_refresh | single_refresh) & ~win_ok;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // 1 kHz enable pulse divider
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_DIV - 32'h1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // key sequence trackers: a wrong value at the same register breaks the pair
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock_half <= 1'b0;
      unlocked    <= 1'b0;
    end else if (wr_count) begin
      unlock_half <= (wdata16 == `WDR_KEY_UNLOCK_A);
      if (unlock_half & (wdata16 == `WDR_KEY_UNLOCK_B)) begin
        unlocked <= 1'b1;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refresh_half <= 1'b0;
    end else if (wr_count) begin
      refresh_half <= (wdata16 == `WDR_KEY_REFRESH_A);
    end
  end

  // writes to other registers leave a half-done pair alone
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_half <= 1'b0;
    end else if (wr_cause) begin
      cause_half <= (wdata8 == `WDR_KEY_CAUSE_A);
    end
  end

  // configuration registers, writable only after unlock
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_control_one <= `WDR_RST_CTRL_ONE;
      monitor_control_two <= `WDR_RST_CTRL_TWO;
      timeout_value_high  <= `WDR_RST_TMO_HIGH;
      timeout_value_low   <= `WDR_RST_TMO_LOW;
      window_value_high   <= `WDR_RST_WIN_BYTE;
      window_value_low    <= `WDR_RST_WIN_BYTE;
      cfg_done            <= 1'b0;
    end else if (cfg_wr) begin
      case (idx)
        `WDR_IDX_CTRL_ONE: begin
          if (be_lo) begin
            monitor_control_one <= wdata8;
            cfg_done            <= 1'b1;
          end
        end
        `WDR_IDX_CTRL_TWO: begin
          if (be_lo) begin
            monitor_control_two[7:0] <= wdata8;
          end
          if (avs_byteenable[1]) begin
            monitor_control_two[9:8] <= avs_writedata[9:8];
          end
        end
        `WDR_IDX_TMO_HIGH: begin
          if (be_lo) begin
            timeout_value_high <= wdata8;
          end
        end
        `WDR_IDX_TMO_LOW: begin
          if (be_lo) begin
            timeout_value_low <= wdata8;
          end
        end
        `WDR_IDX_WIN_HIGH: begin
          if (be_lo) begin
            window_value_high <= wdata8;
          end
        end
        `WDR_IDX_WIN_LOW: begin
          if (be_lo) begin
            window_value_low <= wdata8;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // counter: restarts on a valid refresh, holds at timeout while resetting
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_count_reg <= 16'h0000;
    end else if (refresh | ~enabled) begin
      monitor_count_reg <= 16'h0000;
    end else if (cnt_step & (monitor_count_reg < timeout)) begin
      monitor_count_reg <= monitor_count_reg + 16'h1;
    end
  end

  // system reset pulse; an early refresh before the window opens also fires it
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt      <= 8'h00;
      system_reset <= 1'b0;
      cause_flag   <= 1'b0;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt      <= rst_cnt - 8'h1;
      system_reset <= (rst_cnt != 8'h01);
    end else if (expire | early_refresh) begin
      rst_cnt      <= `WDR_RST_PULSE;
      system_reset <= 1'b1;
      cause_flag   <= 1'b1;
    end else begin
      system_reset <= 1'b0;
    end
  end

  // read mux; captured in the wait-state cycle so data stand at the acknowledge edge
  always @* begin
    next_readdata = 32'h0000_0000;
    case (idx)
      `WDR_IDX_COUNT: begin
        next_readdata = {16'h0000, monitor_count_reg};
      end
      `WDR_IDX_CTRL_ONE: begin
        next_readdata = {24'h0, monitor_control_one};
      end
      `WDR_IDX_CTRL_TWO: begin
        next_readdata = {22'h0, monitor_control_two};
      end
      `WDR_IDX_TMO_HIGH: begin
        next_readdata = {24'h0, timeout_value_high};
      end
      `WDR_IDX_TMO_LOW: begin
        next_readdata = {24'h0, timeout_value_low};
      end
      `WDR_IDX_WIN_HIGH: begin
        next_readdata = {24'h0, window_value_high};
      end
      `WDR_IDX_WIN_LOW: begin
        next_readdata = {24'h0, window_value_low};
      end
      `WDR_IDX_CAUSE: begin
        next_readdata = {29'h0, unlocked, enabled, cause_flag};
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule // wdr_watchdog

//--- rtl/wdr_defines.vh
// register map, field positions, reset values and timing counts of the watchdog
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH
// register word indices (byte address = 4 * index)
`define WDR_IDX_COUNT      3'h0
`define WDR_IDX_CTRL_ONE   3'h1
`define WDR_IDX_CTRL_TWO   3'h2
`define WDR_IDX_TMO_HIGH   3'h3
`define WDR_IDX_TMO_LOW    3'h4
`define WDR_IDX_WIN_HIGH   3'h5
`define WDR_IDX_WIN_LOW    3'h6
`define WDR_IDX_CAUSE      3'h7
// refresh and unlock keys
`define WDR_KEY_REFRESH_A  16'ha602
`define WDR_KEY_REFRESH_B  16'hb480
`define WDR_KEY_UNLOCK_A   16'hc520
`define WDR_KEY_UNLOCK_B   16'hd928
`define WDR_KEY_CAUSE_A    8'h55
`define WDR_KEY_CAUSE_B    8'haa
// control one fields
`define WDR_CTL1_ENABLE    7
`define WDR_CTL1_ALLOW     5
// control two fields
`define WDR_CTL2_CLK_SEL   0
// refresh style selection (bits 9:8 of control two)
`define WDR_STYLE_LO       8
`define WDR_STYLE_HI       9
`define WDR_STYLE_COUNT    2'h0
`define WDR_STYLE_PAIR     2'h1
`define WDR_STYLE_SINGLE   2'h2
// reset values
`define WDR_RST_CTRL_ONE   8'h80
`define WDR_RST_CTRL_TWO   10'h000
`define WDR_RST_TIMEOUT    16'hffff
`define WDR_RST_WINDOW     16'h0000
`define WDR_RST_TMO_HIGH   8'hff
`define WDR_RST_TMO_LOW    8'hff
`define WDR_RST_WIN_BYTE   8'h00
// 1 kHz tick from the 20 MHz clock
`define WDR_CLK_HZ         20000000
`define WDR_TICK_HZ        1000
`define WDR_TICK_DIV       (`WDR_CLK_HZ / `WDR_TICK_HZ)
// system reset pulse length in clock cycles
`define WDR_RST_PULSE      8'h10
`endif

//--- sim/wdr_watchdog_chk.sv
// assertions on bus wait states, reset pulse and cause flag of the watchdog
`timescale 1ns/1ps
module wdr_watchdog_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        system_reset,
  input wire        reset_cause_wdog
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_WAIT_FIRST: assert property (
    $rose(avs_read | avs_write) |-> avs_waitrequest) else $error("no wait state");
  AST_WAIT_ONE: assert property (
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("stall too long");
  AST_PULSE_LEN: assert property (
    $rose(system_reset) |=> system_reset [*8] ##7 system_reset ##1 !system_reset)
    else $error("reset pulse not 16 cycles");
  AST_CAUSE_SET: assert property (
    $rose(system_reset) |-> ##[0:1] reset_cause_wdog) else $error("cause not set");
  AST_CAUSE_HOLD: assert property (
    reset_cause_wdog |=> reset_cause_wdog) else $error("cause flag dropped");
  AST_RD_HOLD: assert property (
    !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  AST_QUIET: assert property (
    disable iff (1'b0) sys_rst |-> !system_reset && !reset_cause_wdog)
    else $error("outputs active in reset");
  AST_CAUSE_RD: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h1c |-> avs_readdata[0] ==
    $past(reset_cause_wdog)) else $error("cause readback wrong");
endmodule // wdr_watchdog_chk

bind wdr_watchdog wdr_watchdog_chk wdr_watchdog_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .system_reset(system_reset), .reset_cause_wdog(reset_cause_wdog));

//--- sim/wdr_watchdog_bench.sv
// self-checking bench of the watchdog: defaults, lock, refresh styles, timeout
`timescale 1ns/1ps
`include "wdr_defines.vh"
module wdr_watchdog_bench;
  reg         clk, sys_rst, avs_read, avs_write;
  reg  [4:0]  avs_address;
  reg  [31:0] avs_writedata, q, rnd;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, system_reset, reset_cause_wdog;
  integer     n_errors, compares, cyc, nfire, k, s, d, t, t0;
  wdr_watchdog #(.TICK_DIV(4)) wdr_watchdog_inst (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .system_reset(system_reset),
    .reset_cause_wdog(reset_cause_wdog));
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error check %0d expected %h seen %h", compares, exp, got);
    end
  endtask
  // request held until waitrequest is seen low; data taken while it stands
  task acc(input r, input [4:0] a, input [31:0] dat);
    avs_read <= r;
    avs_write <= ~r;
    avs_address <= a;
    avs_writedata <= dat;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // refresh in the style under test; a bad second key, or in single style a write to the count register, must not count
  task rf(input good);
    if (s == 0) begin
      acc(0, 5'h00, `WDR_KEY_REFRESH_A);
      acc(0, 5'h00, good ? `WDR_KEY_REFRESH_B : 32'hb481);
    end else if (s == 1) begin
      acc(0, 5'h1c, `WDR_KEY_CAUSE_A);
      acc(0, 5'h1c, good ? `WDR_KEY_CAUSE_B : 32'h33);
    end else
      acc(0, good ? 5'h1c : 5'h00, 32'h0);
  endtask
  task results;
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (system_reset) nfire <= nfire + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    {n_errors, compares, cyc, nfire} = 0;
    {avs_read, avs_write, avs_address, avs_writedata} = 0;
    sys_rst = 1'b1;
    rnd = 32'd73112;
    for (s = 0; s < 3; s = s + 1) begin
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      chk(reset_cause_wdog, 0);
      for (k = 1; k < 7; k = k + 1) begin
        acc(1, k * 4, 0);
        chk(q[7:0], (48'h8000ffff0000 >> (8 * (6 - k))) & 48'hff);
      end
      acc(0, 5'h04, 32'h0);
      acc(1, 5'h04, 0);
      chk(q[7:0], 8'h80);
      acc(0, 5'h00, `WDR_KEY_UNLOCK_A);
      acc(0, 5'h00, `WDR_KEY_UNLOCK_B);
      acc(0, 5'h04, 32'ha0);
      d = (s == 1) ? 4 : 1;
      acc(0, 5'h08, {22'h0, s[1:0], 7'h0, d == 4});
      acc(0, 5'h0c, 32'h03);
      acc(0, 5'h10, 32'he8);
      acc(1, 5'h0c, 0);
      chk(q[7:0], 8'h03);
      rnd = xs(rnd);
      t = 40 + rnd % 24;
      acc(0, 5'h0c, 32'h0);
      rf(1);
      acc(0, 5'h10, t);
      acc(0, 5'h11, 32'h01);
      acc(1, 5'h10, 0);
      chk(q[7:0], t);
      t0 = nfire;
      rf(1);
      for (k = 0; k < 4; k = k + 1) begin
        repeat (t * d / 2) @(posedge clk);
        rf(1);
      end
      chk(nfire, t0);
      t0 = cyc;
      rf(0);
      k = 0;
      while (!system_reset && k < 2000) begin
        @(posedge clk);
        k = k + 1;
      end
      chk(cyc - t0 >= t * d - 4 && cyc - t0 <= t * d + 12, 1);
      repeat (2) @(posedge clk);
      chk(reset_cause_wdog, 1);
      acc(1, 5'h1c, 0);
      chk(q[0], 1);
      $display("style %0d test done", s);
    end
    results;
  end
endmodule // wdr_watchdog_bench
